// ===== acf_filter.sv
/*
  Host command interpreter for the anti-collision filter and echo command,
  plus the filter's autonomous handling of reader anti-collision frames (handled flag and emulator state moves).
  Assumes: host command bytes arrive as valid pulses with a last marker,
  reply bytes leave one per cycle (host side always accepts), reader frames
  arrive as bytes with a last marker and a bit count, listen mode is entered
  by a level from elsewhere in the device.
*/
`timescale 1ns/1ps
`default_nettype none
module acf_filter #(
  parameter int UID_BYTES = 15
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 cmd_valid_i,
  input  wire acf_pkg::acf_byte_t   cmd_byte_i,
  input  wire logic                 listen_i,
  input  wire logic                 rf_valid_i,
  input  wire acf_pkg::acf_rf_byte_t rf_byte_i,
  output acf_pkg::acf_byte_t        rsp_byte_o,
  output logic                      rsp_valid_o,
  output acf_pkg::acf_byte_t        buf_byte_o,
  output logic                      buf_valid_o,
  output logic                      rf_handled_o,
  output logic                      listen_cancel_o,
  output logic                      armed_o,
  output logic               [7:0] emu_state_o
);

  // Refuse at elaboration: three cascade levels need twelve UID bytes
  if (UID_BYTES < 12 || UID_BYTES > 64) begin : g_uid_check
    $error("UID_BYTES out of range");
  end

  // ------------------------------------------------------------------
  // Host command parser
  // ------------------------------------------------------------------
  typedef enum {P_CODE, P_LEN, P_DATA, P_DROP} acf_pstate_t;

  acf_pstate_t pstate, next_pstate;
  logic [7:0]  len, next_len;
  logic [7:0]  cnt, next_cnt;
  logic [7:0]  atq0, next_atq0;
  logic [7:0]  atq1, next_atq1;
  logic [7:0]  sak, next_sak;
  logic [7:0]  first, next_first;
  logic        armed, next_armed;
  logic [7:0]  levels, next_levels;
  logic [7:0]  uid [UID_BYTES], next_uid [UID_BYTES];
  // Reply queue: up to three bytes, shifted out low byte first
  logic [23:0] rq, next_rq;
  logic [1:0]  rn, next_rn;
  logic        cancel, next_cancel;
  logic        force_st;
  logic [7:0]  emu_state;

  function automatic logic [23:0] pack3(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] c);
    pack3 = {c, b, a};
  endfunction

  always_comb begin
    next_pstate = pstate;
    next_len    = len;
    next_cnt    = cnt;
    next_atq0   = atq0;
    next_atq1   = atq1;
    next_sak    = sak;
    next_first  = first;
    next_armed  = armed;
    next_levels = levels;
    next_uid    = uid;
    next_rq     = rq;
    next_rn     = rn;
    next_cancel = 1'b0;
    force_st    = 1'b0;
    if (rn != 2'h0) begin
      next_rq = {8'h00, rq[23:8]};
      next_rn = rn - 2'h1;
    end
    if (cmd_valid_i) begin
      case (pstate)
        P_CODE: begin
          if (cmd_byte_i.data == acf_pkg::CMD_ECHO) begin
            if (listen_i) begin
              next_cancel = 1'b1;
              next_rq = pack3(acf_pkg::CMD_ECHO, acf_pkg::ERR_ABORTED,
                              acf_pkg::LEN_ZERO);
              next_rn = 2'h3;
            end else begin
              next_rq = pack3(acf_pkg::CMD_ECHO, 8'h00, 8'h00);
              next_rn = 2'h1;
            end
          end else if (cmd_byte_i.data == acf_pkg::CMD_FILTER &&
                       !cmd_byte_i.last) begin
            next_pstate = P_LEN;
          end else if (!cmd_byte_i.last) begin
            // Other commands belong to other interpreters
            next_pstate = P_DROP;
          end
        end
        P_LEN: begin
          next_len = cmd_byte_i.data;
          next_cnt = 8'h00;
          next_pstate = cmd_byte_i.last ? P_CODE : P_DATA;
          if (cmd_byte_i.data == acf_pkg::LEN_ZERO) begin
            next_armed = 1'b0;
            next_rq = pack3(acf_pkg::RES_OK, acf_pkg::LEN_ONE, emu_state);
            next_rn = 2'h3;
            next_pstate = cmd_byte_i.last ? P_CODE : P_DROP;
          end else if (cmd_byte_i.data > acf_pkg::LEN_TWO &&
                       cmd_byte_i.data != acf_pkg::LEN_CASCADE1 &&
                       cmd_byte_i.data != acf_pkg::LEN_CASCADE2 &&
                       cmd_byte_i.data != acf_pkg::LEN_CASCADE3) begin
            next_rq = pack3(acf_pkg::ERR_LENGTH, acf_pkg::LEN_ZERO,
                            8'h00);
            next_rn = 2'h2;
            next_pstate = cmd_byte_i.last ? P_CODE : P_DROP;
          end
        end
        P_DATA: begin
          next_cnt = cnt + 8'h01;
          if (cnt == 8'h00) begin
            next_first = cmd_byte_i.data;
            next_atq0  = cmd_byte_i.data;
          end else if (cnt == 8'h01) begin
            next_atq1 = cmd_byte_i.data;
          end else if (cnt == 8'h02) begin
            next_sak = cmd_byte_i.data;
          end else if (int'(cnt) - 3 < UID_BYTES) begin
            next_uid[int'(cnt) - 3] = cmd_byte_i.data;
          end
          if (cnt + 8'h01 == len || cmd_byte_i.last) begin
            next_pstate = cmd_byte_i.last ? P_CODE : P_DROP;
            if (len == acf_pkg::LEN_ONE) begin
              force_st = 1'b1;
              next_rq = pack3(acf_pkg::RES_OK, acf_pkg::LEN_ZERO, 8'h00);
              next_rn = 2'h2;
            end else if (len == acf_pkg::LEN_TWO) begin
              next_rq = pack3(acf_pkg::RES_OK, acf_pkg::LEN_ONE,
                              emu_state);
              next_rn = 2'h3;
            end else begin
              next_armed  = 1'b1;
              next_levels = (len - 8'h03) >> 2;
              next_rq = pack3(acf_pkg::RES_OK, acf_pkg::LEN_ZERO, 8'h00);
              next_rn = 2'h2;
            end
          end
        end
        P_DROP: begin
          if (cmd_byte_i.last) begin
            next_pstate = P_CODE;
          end
        end
        default: next_pstate = P_CODE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pstate <= P_CODE;
      len    <= 8'h00;
      cnt    <= 8'h00;
      atq0   <= 8'h00;
      atq1   <= 8'h00;
      sak    <= 8'h00;
      first  <= 8'h00;
      armed  <= 1'b0;
      levels <= 8'h00;
      uid    <= '{default: 8'h00};
      rq     <= 24'h000000;
      rn     <= 2'h0;
      cancel <= 1'b0;
    end else begin
      pstate <= next_pstate;
      len    <= next_len;
      cnt    <= next_cnt;
      atq0   <= next_atq0;
      atq1   <= next_atq1;
      sak    <= next_sak;
      first  <= next_first;
      armed  <= next_armed;
      levels <= next_levels;
      uid    <= next_uid;
      rq     <= next_rq;
      rn     <= next_rn;
      cancel <= next_cancel;
    end
  end

  // ------------------------------------------------------------------
  // Reader frame filter
  // ------------------------------------------------------------------
  // Frame bytes are forwarded as they arrive; when the frame ends the
  // filter flags it handled or not, and the first two bytes decide.
  logic [7:0] f0, next_f0;
  logic [7:0] f1, next_f1;
  logic [7:0] fn, next_fn;
  logic [2:0] fbits, next_fbits;
  logic       in_frame, next_in_frame;
  logic       fend;
  logic       sense, wakeup, sel, slp, sdd, known;
  logic [7:0] lvl;

  always_comb begin
    next_f0 = f0;
    next_f1 = f1;
    next_fn = fn;
    next_fbits = fbits;
    next_in_frame = in_frame;
    if (rf_valid_i) begin
      if (!in_frame) begin
        next_f0 = rf_byte_i.data;
        next_fbits = rf_byte_i.bits;
        next_fn = 8'h01;
      end else begin
        if (fn == 8'h01) begin
          next_f1 = rf_byte_i.data;
        end
        if (fn != 8'hFF) begin
          next_fn = fn + 8'h01;
        end
      end
      next_in_frame = !rf_byte_i.last;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      f0 <= 8'h00;
      f1 <= 8'h00;
      fn <= 8'h00;
      fbits <= 3'h0;
      in_frame <= 1'b0;
    end else begin
      f0 <= next_f0;
      f1 <= next_f1;
      fn <= next_fn;
      fbits <= next_fbits;
      in_frame <= next_in_frame;
    end
  end

  // Decode on the registered copy one cycle after the last byte
  logic fend_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fend_q <= 1'b0;
    end else begin
      fend_q <= rf_valid_i & rf_byte_i.last;
    end
  end
  assign fend = fend_q;

  always_comb begin
    lvl = (f0 == acf_pkg::RD_SDD1) ? 8'h00 :
          (f0 == acf_pkg::RD_SDD2) ? 8'h01 : 8'h02;
    sense  = fn == 8'h01 && fbits == acf_pkg::SHORT_BITS &&
             f0 == acf_pkg::RD_SENSE;
    wakeup = fn == 8'h01 && fbits == acf_pkg::SHORT_BITS &&
             f0 == acf_pkg::RD_WAKEUP;
    sdd    = (f0 == acf_pkg::RD_SDD1 || f0 == acf_pkg::RD_SDD2 ||
              f0 == acf_pkg::RD_SDD3) && fn >= 8'h02 && lvl < levels;
    sel    = sdd && f1 == acf_pkg::RD_NVB_SEL;
    slp    = fn >= 8'h02 && f0 == acf_pkg::RD_SLEEP &&
             f1 == acf_pkg::RD_SLEEP2;
    known  = armed && (sense || wakeup || sdd || slp);
  end

  logic sel_done;
  assign sel_done = fend && known && sel && (lvl + 8'h01 == levels);

  acf_emu_state u_state (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .force_i       (force_st),
    // Registered copy lags one byte; take the byte arriving now
    .force_value_i (next_first),
    .sense_i       (fend && known && sense),
    .wakeup_i      (fend && known && wakeup),
    .selected_i    (sel_done),
    .sleep_i       (fend && known && slp),
    .state_o       (emu_state)
  );

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_byte_o      <= '0;
      rsp_valid_o     <= 1'b0;
      buf_byte_o      <= '0;
      buf_valid_o     <= 1'b0;
      rf_handled_o    <= 1'b0;
      listen_cancel_o <= 1'b0;
      armed_o         <= 1'b0;
      emu_state_o     <= acf_pkg::ST_RESET;
    end else begin
      rsp_valid_o     <= rn != 2'h0;
      rsp_byte_o      <= '{data: rq[7:0], last: rn == 2'h1};
      // Frames pass straight on; the buffer side drops those flagged handled
      buf_valid_o     <= rf_valid_i;
      buf_byte_o      <= '{data: rf_byte_i.data, last: rf_byte_i.last};
      rf_handled_o    <= fend && known;
      listen_cancel_o <= cancel;
      armed_o         <= armed;
      emu_state_o     <= emu_state;
    end
  end

endmodule : acf_filter
`default_nettype wire

// ===== acf_pkg.sv
/*
  Package for the anti-collision filter and echo command interpreter:
  command codes, result codes, emulator state encoding, reader frame codes.
  Assumes byte-wide host command and reply streams and byte-wide reader frames.
*/
package acf_pkg;

  // ------------------------------------------------------------------
  // Host command and answer codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_FILTER    = 8'h0D;
  localparam logic [7:0] CMD_ECHO      = 8'h55;
  localparam logic [7:0] RES_OK        = 8'h00;
  localparam logic [7:0] ERR_LENGTH    = 8'h82;
  localparam logic [7:0] ERR_ABORTED   = 8'h85;
  localparam logic [7:0] LEN_ZERO      = 8'h00;
  localparam logic [7:0] LEN_ONE       = 8'h01;
  localparam logic [7:0] LEN_TWO       = 8'h02;
  localparam logic [7:0] LEN_CASCADE1  = 8'h07;
  localparam logic [7:0] LEN_CASCADE2  = 8'h0B;
  localparam logic [7:0] LEN_CASCADE3  = 8'h0F;

  // ------------------------------------------------------------------
  // Emulator state byte
  // ------------------------------------------------------------------
  localparam logic [7:0] ST_IDLE         = 8'h00;
  localparam logic [7:0] ST_READY        = 8'h01;
  localparam logic [7:0] ST_ACTIVE       = 8'h04;
  localparam logic [7:0] ST_HALT         = 8'h80;
  localparam logic [7:0] ST_READY_HALT   = 8'h81;
  localparam logic [7:0] ST_ACTIVE_HALT  = 8'h84;
  localparam logic [7:0] ST_RESET        = ST_IDLE;

  // ------------------------------------------------------------------
  // Reader frame codes
  // ------------------------------------------------------------------
  localparam logic [7:0] RD_SENSE   = 8'h26;
  localparam logic [7:0] RD_WAKEUP  = 8'h52;
  localparam logic [7:0] RD_SDD1    = 8'h93;
  localparam logic [7:0] RD_SDD2    = 8'h95;
  localparam logic [7:0] RD_SDD3    = 8'h97;
  localparam logic [7:0] RD_NVB_SEL = 8'h70;
  localparam logic [7:0] RD_SLEEP   = 8'h50;
  localparam logic [7:0] RD_SLEEP2  = 8'h00;
  localparam logic [2:0] SHORT_BITS = 3'h7;
  localparam logic [7:0] SDD_NVB    = 8'h20;

  // One byte on the host command, reply and buffer streams, with a last-of-frame marker
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } acf_byte_t;

  // Reader byte also carries the bit count of a short frame
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic [2:0] bits;
  } acf_rf_byte_t;

endpackage : acf_pkg

// ===== acf_emu_state.sv
/*
  Card emulator state register with the anti-collision state moves.
  Assumes the caller decodes reader frames and host forcing into pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module acf_emu_state (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       force_i,
  input  wire logic [7:0] force_value_i,
  input  wire logic       sense_i,
  input  wire logic       wakeup_i,
  input  wire logic       selected_i,
  input  wire logic       sleep_i,
  output logic      [7:0] state_o
);

  logic [7:0] state;
  logic [7:0] next_state;

  always_comb begin
    next_state = state;
    if (force_i) begin
      next_state = force_value_i;
    end else if (sense_i) begin
      if (state == acf_pkg::ST_IDLE) begin
        next_state = acf_pkg::ST_READY;
      end
    end else if (wakeup_i) begin
      if (state == acf_pkg::ST_IDLE) begin
        next_state = acf_pkg::ST_READY;
      end else if (state == acf_pkg::ST_HALT) begin
        next_state = acf_pkg::ST_READY_HALT;
      end
    end else if (selected_i) begin
      if (state == acf_pkg::ST_READY) begin
        next_state = acf_pkg::ST_ACTIVE;
      end else if (state == acf_pkg::ST_READY_HALT) begin
        next_state = acf_pkg::ST_ACTIVE_HALT;
      end
    end else if (sleep_i) begin
      if (state == acf_pkg::ST_ACTIVE || state == acf_pkg::ST_ACTIVE_HALT)
      begin
        next_state = acf_pkg::ST_HALT;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= acf_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign state_o = state;

endmodule : acf_emu_state
`default_nettype wire

// ===== acf_filter_monitor.sv
/*
  Checker for acf_filter, watching its ports only.
  Assumes host command bytes of one frame arrive on consecutive cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module acf_filter_monitor #(
  parameter int UID_BYTES = 15
) (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  cmd_valid_i,
  input wire acf_pkg::acf_byte_t    cmd_byte_i,
  input wire logic                  listen_i,
  input wire logic                  rf_valid_i,
  input wire acf_pkg::acf_rf_byte_t rf_byte_i,
  input wire acf_pkg::acf_byte_t    rsp_byte_o,
  input wire logic                  rsp_valid_o,
  input wire acf_pkg::acf_byte_t    buf_byte_o,
  input wire logic                  buf_valid_o,
  input wire logic                  rf_handled_o,
  input wire logic                  listen_cancel_o,
  input wire logic                  armed_o,
  input wire logic            [7:0] emu_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ------------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------------
  sequence s_hdr(logic [7:0] len);
    cmd_valid_i && cmd_byte_i.data == 8'h0D
    ##1 cmd_valid_i && cmd_byte_i.data == len;
  endsequence
  sequence s_rsp(logic [7:0] d, bit l);
    rsp_valid_o && rsp_byte_o.data == d && rsp_byte_o.last == l;
  endsequence
  sequence s_echo;
    cmd_valid_i && cmd_byte_i.data == 8'h55 && cmd_byte_i.last;
  endsequence
  sequence s_rf(logic [7:0] d, bit l);
    rf_valid_i && rf_byte_i.data == d && rf_byte_i.last == l;
  endsequence

  // ------------------------------------------------------------------
  // Host command answers
  // ------------------------------------------------------------------
  a_echo_reply: assert property (
    s_echo ##0 !listen_i |-> ##2 s_rsp(8'h55, 1'b1))
    else $error("echo reply wrong");
  a_echo_abort: assert property (
    s_echo ##0 listen_i |-> ##2 s_rsp(8'h55, 1'b0)
    ##1 s_rsp(8'h85, 1'b0) ##1 s_rsp(8'h00, 1'b1))
    else $error("listen abort reply wrong");
  a_cancel_pulse: assert property (
    s_echo ##0 listen_i |-> ##[1:3] listen_cancel_o)
    else $error("listen not cancelled");
  a_bad_length: assert property (
    cmd_valid_i && cmd_byte_i.data == 8'h0D ##1 cmd_valid_i
    && cmd_byte_i.data > 8'h02
    && !(cmd_byte_i.data inside {8'h07, 8'h0B, 8'h0F})
    |-> ##2 s_rsp(8'h82, 1'b0) ##1 s_rsp(8'h00, 1'b1))
    else $error("bad length not refused");
  a_disarm_state: assert property (
    s_hdr(8'h00) ##0 cmd_byte_i.last |-> ##2 s_rsp(8'h00, 1'b0)
    ##1 s_rsp(8'h01, 1'b0) ##1 (s_rsp(emu_state_o, 1'b1) ##0 !armed_o))
    else $error("disarm reply wrong");
  a_get_state: assert property (
    s_hdr(8'h02) ##1 cmd_valid_i ##1 cmd_valid_i |-> ##2 s_rsp(8'h00, 1'b0)
    ##1 s_rsp(8'h01, 1'b0) ##1 (s_rsp(emu_state_o, 1'b1)
    ##0 armed_o == $past(armed_o, 4)))
    else $error("state read wrong");
  a_force_state: assert property (
    s_hdr(8'h01) ##1 cmd_valid_i && cmd_byte_i.last
    |-> ##2 s_rsp(8'h00, 1'b0) ##1 s_rsp(8'h00, 1'b1)
    ##1 emu_state_o == $past(cmd_byte_i.data, 4))
    else $error("state not forced");

  // ------------------------------------------------------------------
  // Reader frames
  // ------------------------------------------------------------------
  a_sense_ready: assert property (
    (armed_o && emu_state_o == 8'h00 && !rf_valid_i)
    ##1 (s_rf(8'h26, 1'b1) ##0 rf_byte_i.bits == 3'h7)
    |-> ##2 rf_handled_o ##1 emu_state_o == 8'h01)
    else $error("sense not handled");
  a_sleep_halt: assert property (
    (armed_o && emu_state_o == 8'h04 && !rf_valid_i)
    ##1 s_rf(8'h50, 1'b0) ##1 s_rf(8'h00, 1'b1)
    |-> ##2 rf_handled_o ##1 emu_state_o == 8'h80)
    else $error("sleep not handled");
  a_buf_copy: assert property (
    rf_valid_i && !armed_o |=> buf_valid_o
    && buf_byte_o.data == $past(rf_byte_i.data)
    && buf_byte_o.last == $past(rf_byte_i.last))
    else $error("frame not buffered");
  a_no_handle: assert property (
    rf_valid_i && rf_byte_i.last && !armed_o |-> ##2 !rf_handled_o)
    else $error("handled while disarmed");
endmodule : acf_filter_monitor

bind acf_filter acf_filter_monitor #(.UID_BYTES(UID_BYTES))
  i_acf_filter_monitor (
  .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
  .cmd_byte_i(cmd_byte_i), .listen_i(listen_i), .rf_valid_i(rf_valid_i),
  .rf_byte_i(rf_byte_i), .rsp_byte_o(rsp_byte_o), .rsp_valid_o(rsp_valid_o),
  .buf_byte_o(buf_byte_o), .buf_valid_o(buf_valid_o),
  .rf_handled_o(rf_handled_o), .listen_cancel_o(listen_cancel_o),
  .armed_o(armed_o), .emu_state_o(emu_state_o)
);
`default_nettype wire

// ===== acf_reader_model.sv
/*
  Reader-side model: sends reader frames one byte per cycle.
  Assumes the caller waits for send to return before the next frame.
*/
`timescale 1ns/1ps
`default_nettype none
module acf_reader_model (
  input  wire logic                  clk_i,
  output var  logic                  rf_valid_o,
  output var  acf_pkg::acf_rf_byte_t rf_byte_o
);
  initial begin
    rf_valid_o = 1'b0;
    rf_byte_o  = '0;
  end

  task automatic send(input logic [7:0] b[$], input logic [2:0] bits);
    int i;
    for (i = 0; i < b.size(); i++) begin
      @(negedge clk_i);
      rf_valid_o = 1'b1;
      rf_byte_o  = {b[i], i == b.size() - 1, bits};
    end
    @(negedge clk_i);
    rf_valid_o = 1'b0;
    // Released line shows the inverse, never a stale copy
    rf_byte_o.data = ~rf_byte_o.data;
    // Idle gap keeps frames apart
    repeat (4) @(negedge clk_i);
  endtask : send
endmodule : acf_reader_model
`default_nettype wire

// ===== tb_acf_filter.sv
/*
  Self-checking bench for acf_filter with a reader model on the RF side.
  Assumes acf_pkg, acf_filter and acf_reader_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_acf_filter;
  logic                  clk_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  cmd_valid_i = 1'b0;
  acf_pkg::acf_byte_t    cmd_byte_i = '0;
  logic                  listen_i = 1'b0;
  logic                  rf_valid_i;
  acf_pkg::acf_rf_byte_t rf_byte_i;
  acf_pkg::acf_byte_t    rsp_byte_o, buf_byte_o;
  logic                  rsp_valid_o, buf_valid_o, rf_handled_o;
  logic                  listen_cancel_o, armed_o;
  logic            [7:0] emu_state_o;
  int                    fail_count = 0, n_compared = 0;
  int                    cyc = 0, nh = 0, nc = 0;
  logic            [7:0] rq[$], bq[$];

  always #2.5 clk_i = ~clk_i;

  acf_filter #(.UID_BYTES(15)) i_acf_filter (
    .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_byte_i(cmd_byte_i), .listen_i(listen_i), .rf_valid_i(rf_valid_i),
    .rf_byte_i(rf_byte_i), .rsp_byte_o(rsp_byte_o),
    .rsp_valid_o(rsp_valid_o), .buf_byte_o(buf_byte_o),
    .buf_valid_o(buf_valid_o), .rf_handled_o(rf_handled_o),
    .listen_cancel_o(listen_cancel_o), .armed_o(armed_o),
    .emu_state_o(emu_state_o));
  acf_reader_model i_acf_reader_model (
    .clk_i(clk_i), .rf_valid_o(rf_valid_i), .rf_byte_o(rf_byte_i));

  // ------------------------------------------------------------------
  // Capture and helpers
  // ------------------------------------------------------------------
  always @(negedge clk_i) begin
    if (rsp_valid_o === 1'b1) rq.push_back(rsp_byte_o.data);
    if (buf_valid_o === 1'b1) bq.push_back(buf_byte_o.data);
    if (rf_handled_o === 1'b1) nh++;
    if (listen_cancel_o === 1'b1) nc++;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic send_cmd(input logic [7:0] b[$]);
    int i;
    rq.delete();
    for (i = 0; i < b.size(); i++) begin
      @(negedge clk_i);
      cmd_valid_i = 1'b1;
      cmd_byte_i  = {b[i], i == b.size() - 1};
    end
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    // Longest reply is three bytes after a two cycle delay
    repeat (8) @(negedge clk_i);
  endtask : send_cmd

  task automatic exp(input logic [7:0] e[$]);
    chk("reply count", 8'(e.size()), 8'(rq.size()));
    foreach (e[i]) chk("reply byte", e[i], rq[i]);
  endtask : exp

  task automatic rd(input logic [7:0] b[$], input logic [2:0] bits,
                    input logic eh, input logic [7:0] es);
    nh = 0;
    bq.delete();
    i_acf_reader_model.send(b, bits);
    chk("handled", {7'h0, eh}, {7'h0, nh != 0});
    chk("emu state", es, emu_state_o);
    if (!eh) begin
      chk("buffered count", 8'(b.size()), 8'(bq.size()));
      chk("buffered byte", b[0], bq[0]);
    end
  endtask : rd

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_echo();
    chk("reset state", acf_pkg::ST_RESET, emu_state_o);
    send_cmd('{8'h55});
    exp('{8'h55});
  endtask : t_echo

  task automatic t_bad_len();
    logic [7:0] bad[4] = '{8'h03, 8'h08, 8'h0E, 8'hFF};
    foreach (bad[i]) begin
      send_cmd('{8'h0D, bad[i]});
      exp('{8'h82, 8'h00});
      chk("armed", 8'h00, {7'h0, armed_o});
    end
  endtask : t_bad_len

  task automatic t_arm();
    send_cmd('{8'h0D, 8'h07, 8'h44, 8'h00, 8'h08,
               8'h11, 8'h22, 8'h33, 8'h44});
    exp('{8'h00, 8'h00});
    chk("armed", 8'h01, {7'h0, armed_o});
    send_cmd('{8'h0D, 8'h02, 8'h00, 8'h00});
    exp('{8'h00, 8'h01, acf_pkg::ST_IDLE});
    chk("armed", 8'h01, {7'h0, armed_o});
  endtask : t_arm

  task automatic t_collide();
    listen_i = 1'b1;
    nc = 0;
    rd('{8'h26}, 3'h7, 1'b1, acf_pkg::ST_READY);
    rd('{8'h93, 8'h20}, 3'h0, 1'b1, acf_pkg::ST_READY);
    rd('{8'h93, 8'h70, 8'h11, 8'h22, 8'h33, 8'h44, 8'h44}, 3'h0,
       1'b1, acf_pkg::ST_ACTIVE);
    rd('{8'h50, 8'h00}, 3'h0, 1'b1, acf_pkg::ST_HALT);
    rd('{8'h52}, 3'h7, 1'b1, acf_pkg::ST_READY_HALT);
    rd('{8'h30, 8'h04}, 3'h0, 1'b0, acf_pkg::ST_READY_HALT);
    chk("cancel pulses", 8'h00, 8'(nc));
    listen_i = 1'b0;
  endtask : t_collide

  task automatic t_cascade();
    send_cmd('{8'h0D, 8'h0B, 8'h44, 8'h00, 8'h08, 8'h88, 8'h01,
               8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
    exp('{8'h00, 8'h00});
    send_cmd('{8'h0D, 8'h01, 8'h00});
    exp('{8'h00, 8'h00});
    rd('{8'h52}, 3'h7, 1'b1, acf_pkg::ST_READY);
    rd('{8'h93, 8'h70, 8'h88, 8'h01, 8'h02, 8'h03, 8'h8A}, 3'h0,
       1'b1, acf_pkg::ST_READY);
    rd('{8'h95, 8'h70, 8'h04, 8'h05, 8'h06, 8'h07, 8'h00}, 3'h0,
       1'b1, acf_pkg::ST_ACTIVE);
    rd('{8'h97, 8'h20}, 3'h0, 1'b0, acf_pkg::ST_ACTIVE);
    send_cmd('{8'h0D, 8'h01, 8'h84});
    exp('{8'h00, 8'h00});
  endtask : t_cascade

  task automatic t_force();
    logic [7:0] st[6] = '{8'h00, 8'h01, 8'h04, 8'h80, 8'h81, 8'h84};
    foreach (st[i]) begin
      send_cmd('{8'h0D, 8'h01, st[i]});
      exp('{8'h00, 8'h00});
      chk("forced state", st[i], emu_state_o);
      send_cmd('{8'h0D, 8'h02, 8'h00, 8'h00});
      exp('{8'h00, 8'h01, st[i]});
    end
  endtask : t_force

  task automatic t_disarm();
    send_cmd('{8'h0D, 8'h00});
    exp('{8'h00, 8'h01, acf_pkg::ST_ACTIVE_HALT});
    chk("armed", 8'h00, {7'h0, armed_o});
    rd('{8'h26}, 3'h7, 1'b0, acf_pkg::ST_ACTIVE_HALT);
  endtask : t_disarm

  task automatic t_cancel();
    listen_i = 1'b1;
    nc = 0;
    send_cmd('{8'h55});
    exp('{8'h55, 8'h85, 8'h00});
    chk("cancel pulses", 8'h01, 8'(nc));
    listen_i = 1'b0;
  endtask : t_cancel

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    t_echo();
    t_bad_len();
    t_arm();
    t_collide();
    t_force();
    t_cascade();
    t_disarm();
    t_cancel();
    summarize();
  end
endmodule : tb_acf_filter
`default_nettype wire
